//--- rtl/sram_host_ctrl.sv
// Purpose: host controller sequencing reads and writes to an async byte memory
// Assumes: pins registered in the pin stage, one cycle after the sequencer
// Notes: strobe-controlled writes with the output gate held high
`timescale 1ns/10ps
`default_nettype none
module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  output logic               req_ready,
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_rdata,
  output logic [AW-1:0]      mem_addr,
  output logic               select_low_active,
  output logic               select_high_active,
  output logic               write_strobe_n,
  output logic               output_gate_n,
  output logic [DW-1:0]      data_out,
  output logic               data_oe,
  input  wire logic [DW-1:0] data_in
);

  // every load must fit the down counter
  if (AW < 1 || DW < 1 || READ_CYCLES + RD_PIPE_CYCLES >= (1 << CNT_W) ||
      WRITE_LOW_CYCLES > (1 << CNT_W) || FLOAT_CYCLES > (1 << CNT_W))
  begin : g_bad_params
    $error("sram_host_ctrl: unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////
  pin_bus_if #(.AW(AW), .DW(DW)) bus ();

  state_t         state;
  state_t         next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [AW-1:0]  addr;
  logic [DW-1:0]  wdata;
  logic           is_write;

  wire cnt_done   = (cnt == CNT_ZERO);
  wire take       = req_valid && (state == ST_IDLE);
  // two more cycles: pin register plus the first sync stage
  wire [CNT_W-1:0] rd_load = CNT_W'(READ_CYCLES + RD_PIPE_CYCLES);
  wire [CNT_W-1:0] wr_load = CNT_W'(WRITE_LOW_CYCLES - 1);
  wire [CNT_W-1:0] fl_load = CNT_W'(FLOAT_CYCLES - 1);

  assign req_ready = (state == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt_done ? CNT_ZERO : cnt - CNT_ONE;
    case (state)
      ST_IDLE:
        if (req_valid)
          next_state = req_write ? ST_WR_SETUP : ST_RD_SETUP;
      // address first, select after: address valid at select edge
      ST_RD_SETUP:
      begin
        next_state = ST_RD_WAIT;  // RULE13
        next_cnt   = rd_load;     // RULE9
      end
      ST_RD_WAIT:
        if (cnt_done)
        begin
          next_state = ST_FLOAT;
          next_cnt   = fl_load;
        end
      ST_WR_SETUP:
      begin
        next_state = ST_WR_LOW;   // RULE5
        next_cnt   = wr_load;     // RULE8 RULE11 RULE12
      end
      ST_WR_LOW:
        if (cnt_done)
          next_state = ST_WR_END;
      // strobe rises, data and address held one more cycle
      ST_WR_END:
      begin
        next_state = ST_FLOAT;    // RULE6
        next_cnt   = fl_load;
      end
      ST_FLOAT:
        if (cnt_done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state    <= ST_IDLE;
      cnt      <= CNT_ZERO;
      addr     <= '0;
      wdata    <= '0;
      is_write <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      if (take)
      begin
        addr     <= req_addr;
        wdata    <= req_wdata;
        is_write <= req_write;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  wire in_rd = (state == ST_RD_WAIT);
  wire in_wr = (state == ST_WR_SETUP) || (state == ST_WR_LOW) || (state == ST_WR_END);

  assign bus.addr     = addr;
  assign bus.sel_n    = ~(in_rd || in_wr);                          // RULE1
  assign bus.gate_n   = ~in_rd;                                     // RULE3
  assign bus.strobe_n = ~(state == ST_WR_LOW);                      // RULE4 RULE5
  assign bus.wdata    = wdata;
  // gate high since float period; memory is not driving
  assign bus.drive    = in_wr;                                      // RULE7 RULE2

  // sample last: old data would still hold 10 ns after an address move
  wire rd_last = in_rd && cnt_done;                                 // RULE10

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= rd_last || (state == ST_WR_END);
      if (rd_last)
        rsp_rdata <= bus.rdata;
    end
  end

  sram_pin_stage #(.AW(AW), .DW(DW)) u_pins (
    .mclk               (mclk),
    .rstn               (rstn),
    .bus                (bus),
    .mem_addr           (mem_addr),
    .select_low_active  (select_low_active),
    .select_high_active (select_high_active),
    .write_strobe_n     (write_strobe_n),
    .output_gate_n      (output_gate_n),
    .data_out           (data_out),
    .data_oe            (data_oe),
    .data_in            (data_in)
  );

endmodule : sram_host_ctrl
`default_nettype wire

//--- rtl/sram_host_pkg.sv
// Purpose: constants and types for the byte-wide async static memory host controller
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: nanosecond limits are turned into whole clock cycles here
// Notes on behaviour
// RULE1: select active only when low-low, high-high
// RULE2: memory floats data when deselected or gated
// RULE3: read: selected, strobe high, gate low
// RULE4: storing happens only during strobe-select overlap
// RULE5: all qualifiers active begin write; one ends
// RULE6: data timed against the write-ending edge
// RULE7: no host drive while memory still drives
// RULE8: strobe low covers float plus setup time
// RULE9: read data valid 45 ns after address
// RULE10: old data holds 10 ns after address
// RULE11: address stable 35 ns before write end
// RULE12: data valid 25 ns before write end
// RULE13: address valid before select goes active (writes: select goes active on the same edge as the address)
// RULE14: nanosecond limits round up to cycles
package sram_host_pkg;

  localparam int CLK_PERIOD_PS = 10000;

  // limits in picoseconds, figures as printed in ns
  localparam int READ_ACCESS_PS           = 45000;
  localparam int READ_HOLD_PS             = 10000;
  localparam int ADDR_SETUP_WRITE_PS      = 35000;
  localparam int WRITE_DATA_SETUP_PS      = 25000;
  localparam int STROBE_TO_FLOAT_PS       = 18000;
  localparam int WRITE_CYCLE_PS           = 45000;
  localparam int GATE_TO_FLOAT_PS         = 18000;

  function automatic int cycles_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cycles_up

  localparam int READ_CYCLES      = cycles_up(READ_ACCESS_PS);          // RULE14
  localparam int STROBE_CYCLES    = cycles_up(STROBE_TO_FLOAT_PS + WRITE_DATA_SETUP_PS);
  localparam int WRITE_LOW_CYCLES = (cycles_up(ADDR_SETUP_WRITE_PS) > STROBE_CYCLES)
                                    ? cycles_up(ADDR_SETUP_WRITE_PS) : STROBE_CYCLES;
  localparam int FLOAT_CYCLES     = cycles_up(GATE_TO_FLOAT_PS);
  // pin register plus the first sync stage ahead of the read sample
  localparam int RD_PIPE_CYCLES   = 2;
  localparam int CNT_W            = 4;

  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  typedef enum {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_LOW,
    ST_WR_END,
    ST_FLOAT
  } state_t;

endpackage : sram_host_pkg

//--- rtl/pin_bus_if.sv
// Purpose: carries the memory pin group between the sequencer and the pin stage
// Assumes: all signals on mclk
// Notes: pin levels are in device polarity except the high-active select, inverted from sel_n in the pin stage
`timescale 1ns/10ps
`default_nettype none
interface pin_bus_if #(
  parameter int AW = 20,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic          sel_n;
  logic          strobe_n;
  logic          gate_n;
  logic [DW-1:0] wdata;
  logic          drive;
  logic [DW-1:0] rdata;

  modport seq (output addr, output sel_n, output strobe_n, output gate_n,
               output wdata, output drive, input rdata);
  modport pins (input addr, input sel_n, input strobe_n, input gate_n,
                input wdata, input drive, output rdata);
endinterface : pin_bus_if
`default_nettype wire

//--- rtl/sram_pin_stage.sv
// Purpose: registers every memory pin and synchronises read data
// Assumes: pins go straight to the memory package
// Notes: read data pass two flip-flops before use
`timescale 1ns/10ps
`default_nettype none
module sram_pin_stage
  import sram_host_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  pin_bus_if.pins            bus,
  output logic [AW-1:0]      mem_addr,
  output logic               select_low_active,
  output logic               select_high_active,
  output logic               write_strobe_n,
  output logic               output_gate_n,
  output logic [DW-1:0]      data_out,
  output logic               data_oe,
  input  wire logic [DW-1:0] data_in
);

  logic [DW-1:0] data_meta;
  logic [DW-1:0] data_sync;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      mem_addr           <= '0;
      select_low_active  <= 1'b1;
      select_high_active <= 1'b0;
      write_strobe_n     <= 1'b1;
      output_gate_n      <= 1'b1;
      data_out           <= '0;
      data_oe            <= 1'b0;
    end
    else
    begin
      mem_addr           <= bus.addr;
      select_low_active  <= bus.sel_n;   // RULE1
      select_high_active <= ~bus.sel_n;  // RULE1
      write_strobe_n     <= bus.strobe_n;
      output_gate_n      <= bus.gate_n;
      data_out           <= bus.wdata;
      data_oe            <= bus.drive;
    end
  end

  // two stages: pin data is asynchronous to mclk
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      data_meta <= '0;
      data_sync <= '0;
    end
    else
    begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  assign bus.rdata = data_sync;

endmodule : sram_pin_stage
`default_nettype wire

//--- tb/sram_host_chk.sv
// Purpose: port checker for the memory host controller
// Assumes: single mclk domain
// Notes: pin figures are cycles at 100 MHz
`timescale 1ns/10ps
`default_nettype none
module sram_host_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        rsp_valid,
  input wire logic [19:0] mem_addr,
  input wire logic        select_low_active,
  input wire logic        select_high_active,
  input wire logic        write_strobe_n,
  input wire logic        output_gate_n,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_sel_pair: assert property (select_high_active == !select_low_active)
    else $error("select pins not complementary");
  a_idle_pins: assert property (select_low_active |-> write_strobe_n && output_gate_n && !data_oe)
    else $error("strobe or drive while deselected");
  a_read_mode: assert property (!output_gate_n |-> write_strobe_n && !select_low_active)
    else $error("gate low outside a read");
  a_write_qual: assert property (!write_strobe_n |-> !select_low_active && data_oe && output_gate_n)
    else $error("write without all qualifiers");
  a_strobe_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*5] ##1 write_strobe_n)
    else $error("strobe width wrong");
  a_write_hold: assert property (!write_strobe_n |=> $stable(mem_addr) && $stable(data_out) && data_oe)
    else $error("address or data moved at write end");
  a_read_len: assert property ($fell(output_gate_n) |-> ($stable(mem_addr) && !output_gate_n)[*5])
    else $error("read too short or address late");
  // memory may still drive for 18 ns after the gate rises
  a_float_gap: assert property ($rose(output_gate_n) |-> !data_oe[*2])
    else $error("host drove data during float");
  c_read: cover property ($fell(output_gate_n));
  c_write: cover property ($fell(write_strobe_n));
  c_rsp: cover property (rsp_valid);
endmodule : sram_host_chk
bind sram_host_ctrl sram_host_chk sram_host_chk_inst (.*);
`default_nettype wire

//--- tb/sram_model.sv
// Purpose: behavioural byte memory on the far side
// Assumes: pins straight from the controller
// Notes: undriven data shows the inverse of the last read
`timescale 1ns/10ps
`default_nettype none
module sram_model #(
  parameter int ACC_NS = 45
) (
  input wire logic [19:0] mem_addr,
  input wire logic        select_low_active,
  input wire logic        select_high_active,
  input wire logic        write_strobe_n,
  input wire logic        output_gate_n,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe,
  output logic [7:0]      data_in,
  output logic            fault
);
  logic [7:0] mem [0:1048575];
  logic [7:0] last     = 8'h00;
  logic       fault_wr = 1'b0;
  logic       fault_ta = 1'b0;
  logic       wr_seen  = 1'b0;
  realtime    t_data   = 0.0;
  realtime    t_addr   = 0.0;
  realtime    t_rd_off = -100.0;
  wire sel = !select_low_active && select_high_active;
  wire rd = sel && write_strobe_n && !output_gate_n;
  wire wr_on = sel && !write_strobe_n;
  wire rd_late;
  wire [19:0] addr_d;
  wire [7:0]  data_d;
  wire        oe_d;
  assign #ACC_NS rd_late = rd;
  // pins seen 1 ns late: the values that stood just before an ending edge
  assign #1 addr_d = mem_addr;
  assign #1 data_d = data_out;
  assign #1 oe_d = data_oe;
  assign data_in = (rd && rd_late) ? mem[mem_addr] : ~last;
  assign fault = fault_wr || fault_ta;
  always @(posedge rd_late) last = mem[mem_addr];
  always @(addr_d) t_addr = $realtime;
  always @(data_d or oe_d) t_data = $realtime;
  // store at whichever qualifier ends the overlap, reset included
  always @(wr_on)
    if (wr_on === 1'b1)
      wr_seen = 1'b1;
    else if (wr_seen)
    begin
      wr_seen = 1'b0;
      mem[addr_d] = data_d;
      if (oe_d !== 1'b1 || $realtime - t_data < 24.0) fault_wr = 1'b1;
      if ($realtime - t_addr < 34.0) fault_wr = 1'b1;
    end
  always @(negedge rd) t_rd_off = $realtime;
  // memory output may float up to 18 ns after a read ends
  always @(posedge data_oe)
    if (rd === 1'b1 || $realtime - t_rd_off < 18.0) fault_ta = 1'b1;
endmodule : sram_model
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for the memory host controller
// Assumes: 100 MHz mclk, sync active-low reset
// Notes: rows first, then a reset in mid-write
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        mclk, rstn, req_valid, req_write, req_ready, rsp_valid;
  logic [19:0] req_addr, mem_addr;
  logic [7:0]  req_wdata, rsp_rdata, data_out, data_in;
  logic        select_low_active, select_high_active, write_strobe_n;
  logic        output_gate_n, data_oe, fault;
  int          failures, cmp_count, n;
  typedef struct {logic wr; logic [19:0] a; logic [7:0] d;} row_t;
  // reads carry the byte they should return
  row_t rows [8] = '{'{1'b1, 20'h00000, 8'ha5}, '{1'b1, 20'hfffff, 8'h5a},
    '{1'b1, 20'h12345, 8'h3c}, '{1'b0, 20'h00000, 8'ha5}, '{1'b0, 20'hfffff, 8'h5a},
    '{1'b1, 20'h00000, 8'hc3}, '{1'b0, 20'h00000, 8'hc3}, '{1'b0, 20'h12345, 8'h3c}};
  sram_host_ctrl sram_host_ctrl_inst (.*);
  sram_model sram_model_inst (.*);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic start(input logic wr, input logic [19:0] a, input logic [7:0] d);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    do
      @(negedge mclk);
    while (req_ready !== 1'b1);
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask : start
  task automatic op(input logic wr, input logic [19:0] a, input logic [7:0] d);
    start(wr, a, d);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 30)
    begin
      @(negedge mclk);
      n++;
    end
    chk(n < 30, 1'b1);
  endtask : op
  task automatic test_done();
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // about 130 cycles expected; generous margin
  initial
  begin
    #20000;
    failures++;
    test_done();
  end
  initial
  begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 20'h00000;
    req_wdata = 8'h00;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk({select_low_active, select_high_active, write_strobe_n, output_gate_n, data_oe}, 5'h16);
    foreach (rows[i])
    begin
      op(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rsp_rdata, rows[i].d);
    end
    start(1'b1, 20'h00abc, 8'hee);
    repeat (4) @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk({select_low_active, select_high_active, write_strobe_n, data_oe, rsp_valid, req_ready}, 6'h29);
    @(posedge mclk);
    rstn <= 1'b1;
    op(1'b0, 20'h00000, 8'h00);
    chk(rsp_rdata, 8'hc3);
    chk(fault, 1'b0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
